// ### shared/fpme_cfg.svh
// offsets, field positions, reset values and codes of the flash controller
`ifndef FPME_CFG_SVH
`define FPME_CFG_SVH
`define FPME_OFS_CFG 6'h00
`define FPME_OFS_PROT 6'h04
`define FPME_OFS_SEC 6'h08
`define FPME_OFS_CMD 6'h0c
`define FPME_OFS_STAT 6'h10
`define FPME_OFS_ARRAY 6'h20
`define FPME_CFG_EMPTY_IE 7
`define FPME_CFG_DONE_IE 6
`define FPME_CFG_KEY_GATE 5
`define FPME_ST_EMPTY 7
`define FPME_ST_DONE 6
`define FPME_ST_PROTECT_VIOLATION_FLAG 5
`define FPME_ST_ACCERR 4
`define FPME_CMD_MASS_ERASE 8'h41
`define FPME_KEY_ON_CODE 2'h2
`define FPME_INVALID_RD 32'hffffffff
`define FPME_CFG_RST 8'h00
`define FPME_PROT_RST 8'hff
`define FPME_SEC_RST 8'h00
`endif

// ### shared/fpme_pkg.sv
// types shared by the flash controller files
package fpme_pkg;
	typedef struct packed {
		logic open;
		logic rsvd;
		logic hiDis;
		logic [1:0] hiSize;
		logic loDis;
		logic [1:0] loSize;
	} fpme_prot_type;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_ADDR, SEQ_CMD} fpme_seq_type;
	typedef enum logic {ENG_IDLE, ENG_RUN} fpme_eng_type;
endpackage

// ### hdl/fpme_erase_engine.sv
// embedded mass erase walker over every array address
`timescale 1ns/1ps
`default_nettype none
module fpme_erase_engine import fpme_pkg::*; #(
	parameter int ADDR_W = 13
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic start,
	output logic busy,
	output logic eraseStb,
	output logic [ADDR_W-1:0] eraseAddr
);
	fpme_eng_type state_q;
	logic lastAddr;

	assign lastAddr = &eraseAddr;
	assign busy = (state_q == ENG_RUN);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ENG_IDLE;
			eraseStb <= 1'b0;
			eraseAddr <= '0;
		end else begin
			unique case (state_q)
				ENG_IDLE: begin
					eraseStb <= start;
					eraseAddr <= '0;
					if (start) begin
						state_q <= ENG_RUN;
					end
				end
				ENG_RUN: begin
					if (lastAddr) begin
						state_q <= ENG_IDLE;
						eraseStb <= 1'b0;
					end else begin
						eraseAddr <= eraseAddr + 1'b1;
					end
				end
			endcase
		end
	end

	chk_erase_step: assert property (@(posedge ref_clk) disable iff (!resetn)
		eraseStb && !lastAddr |=> eraseStb && eraseAddr == $past(eraseAddr) + 1'b1)
		else $error("erase address did not advance by one");
endmodule
`default_nettype wire

// ### hdl/fpme_core.sv
// flash controller: configuration, protection and mass erase sequencing
`timescale 1ns/1ps
`default_nettype none
`include "fpme_cfg.svh"
// Overview of operation
// - empty flag plus enable raises interrupt
// - done flag plus enable raises interrupt
// - key gate turns array writes into keys
// - key gate writable only when keys enabled
// - other configuration bits read zero
// - protection loaded from array after reset
// - protection may only be added
// - disallowed protection write discarded entirely
// - protection readable in every mode
// - open selector only goes one to zero
// - low size frozen once low disable cleared
// - mass erase walks whole array internally
// - writing one to empty flag launches
// - protected area: set violation, no launch
// - done sets after erase unless sequence buffered or half written
module fpme_core import fpme_pkg::*; #(
	parameter int ADDR_W = 13
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] nvmProt,
	input wire logic [7:0] nvmSec,
	input wire logic [31:0] arrayRdData,
	output logic bufEmptyIrq,
	output logic doneIrq,
	output logic keyWordStb,
	output logic [31:0] keyWord,
	output logic eraseStb,
	output logic [ADDR_W-1:0] eraseAddr
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] cfg_q;
	fpme_prot_type prot_q;
	logic [7:0] sec_q;
	logic [7:0] cmd_q;
	logic loadPend_q;
	fpme_seq_type seq_q;
	logic bufFull_q;
	logic doneFlag_q;
	logic protect_violation_flag_q;
	logic accErr_q;
	logic engBusy;
	logic engStart;
	logic bufEmpty;
	logic acc;
	logic wrLo;
	logic keyOn;
	logic keyGate;
	logic anyProt;
	logic launchTry;
	logic launchOk;
	logic protOk;
	fpme_prot_type protNew;
	logic [7:0] statRd;

	// ----------------------------------------------------------------
	// bus slave: one wait cycle, then the access completes
	// ----------------------------------------------------------------
	// an access completes on the edge where waitrequest is seen low
	assign acc = !avs_waitrequest && (avs_read || avs_write);
	assign wrLo = acc && avs_write && avs_byteenable[0];

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			avs_waitrequest <= 1'b1;
		end else if (avs_waitrequest) begin
			avs_waitrequest <= loadPend_q || !(avs_read || avs_write);
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	assign statRd = {bufEmpty, doneFlag_q, protect_violation_flag_q, accErr_q, 4'h0};

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			avs_readdata <= '0;
		end else if (avs_waitrequest && avs_read) begin
			unique case (avs_address)
				`FPME_OFS_CFG: avs_readdata <= {24'h0, cfg_q};
				`FPME_OFS_PROT: avs_readdata <= {24'h0, prot_q};
				`FPME_OFS_SEC: avs_readdata <= {24'h0, sec_q};
				`FPME_OFS_CMD: avs_readdata <= {24'h0, cmd_q};
				`FPME_OFS_STAT: avs_readdata <= {24'h0, statRd};
				// invalid data while keys are taken
				`FPME_OFS_ARRAY: avs_readdata <= keyGate ?
					`FPME_INVALID_RD : arrayRdData;
				default: avs_readdata <= '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// configuration and security
	// ----------------------------------------------------------------
	assign keyOn = (sec_q[7:6] == `FPME_KEY_ON_CODE);
	assign keyGate = cfg_q[`FPME_CFG_KEY_GATE];

	// only the three control bits are stored
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cfg_q <= `FPME_CFG_RST;
		end else if (wrLo && avs_address == `FPME_OFS_CFG) begin
			cfg_q[`FPME_CFG_EMPTY_IE] <= avs_writedata[`FPME_CFG_EMPTY_IE];
			cfg_q[`FPME_CFG_DONE_IE] <= avs_writedata[`FPME_CFG_DONE_IE];
			if (keyOn) begin
				cfg_q[`FPME_CFG_KEY_GATE] <=
					avs_writedata[`FPME_CFG_KEY_GATE];
			end
		end
	end

	// take the array copy on the first edge after reset
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			loadPend_q <= 1'b1;
			sec_q <= `FPME_SEC_RST;
		end else if (loadPend_q) begin
			loadPend_q <= 1'b0;
			sec_q <= nvmSec;
		end
	end

	// ----------------------------------------------------------------
	// protection
	// ----------------------------------------------------------------
	assign protNew = fpme_prot_type'(avs_writedata[7:0]);

	// each check forbids a step that removes protection
	// low size frozen once low disable is clear
	assign protOk = !(!prot_q.open && protNew.open) &&
		!(!prot_q.hiDis && protNew.hiDis) &&
		!(!prot_q.loDis && protNew.loDis) &&
		(prot_q.loDis || protNew.loSize == prot_q.loSize) &&
		(prot_q.hiDis || protNew.hiSize == prot_q.hiSize);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			prot_q <= fpme_prot_type'(`FPME_PROT_RST);
		end else if (loadPend_q) begin
			prot_q <= fpme_prot_type'(nvmProt);
			prot_q.rsvd <= 1'b1;
		end else if (wrLo && avs_address == `FPME_OFS_PROT && protOk) begin
			// only a whole valid write lands
			prot_q <= protNew;
			prot_q.rsvd <= 1'b1;
		end
	end

	// with open clear everything outside the regions is protected
	assign anyProt = !prot_q.open || !prot_q.hiDis || !prot_q.loDis;

	// ----------------------------------------------------------------
	// command write sequence
	// ----------------------------------------------------------------
	assign bufEmpty = !bufFull_q;
	// a written one on the empty flag is the launch
	assign launchTry = wrLo && avs_address == `FPME_OFS_STAT &&
		avs_writedata[`FPME_ST_EMPTY] && bufEmpty && seq_q == SEQ_CMD;
	assign launchOk = launchTry && !anyProt;

	// array write, then code, then launch
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			seq_q <= SEQ_IDLE;
			cmd_q <= '0;
		end else if (launchTry) begin
			seq_q <= SEQ_IDLE;
		end else if (wrLo && avs_address == `FPME_OFS_ARRAY &&
			!keyGate && bufEmpty) begin
			// plain array write opens a sequence
			seq_q <= SEQ_ADDR;
		end else if (wrLo && avs_address == `FPME_OFS_CMD) begin
			if (seq_q == SEQ_ADDR &&
				avs_writedata[7:0] == `FPME_CMD_MASS_ERASE) begin
				seq_q <= SEQ_CMD;
				cmd_q <= avs_writedata[7:0];
			end else begin
				seq_q <= SEQ_IDLE;
			end
		end
	end

	// array writes under the gate are key words
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			keyWordStb <= 1'b0;
			keyWord <= '0;
		end else begin
			keyWordStb <= wrLo && avs_address == `FPME_OFS_ARRAY && keyGate;
			if (wrLo && avs_address == `FPME_OFS_ARRAY && keyGate) begin
				keyWord <= avs_writedata;
			end
		end
	end

	// bad code or out of order code write
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			accErr_q <= 1'b0;
		end else if (wrLo && avs_address == `FPME_OFS_CMD &&
			!(seq_q == SEQ_ADDR &&
			avs_writedata[7:0] == `FPME_CMD_MASS_ERASE)) begin
			accErr_q <= 1'b1;
		end else if (wrLo && avs_address == `FPME_OFS_STAT &&
			avs_writedata[`FPME_ST_ACCERR]) begin
			accErr_q <= 1'b0;
		end
	end

	// violation flag, set wins over clear
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			protect_violation_flag_q <= 1'b0;
		end else if (launchTry && anyProt) begin
			protect_violation_flag_q <= 1'b1;
		end else if (wrLo && avs_address == `FPME_OFS_STAT &&
			avs_writedata[`FPME_ST_PROTECT_VIOLATION_FLAG]) begin
			protect_violation_flag_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// command buffer and completion
	// ----------------------------------------------------------------
	// single buffer stage ahead of the engine
	assign engStart = bufFull_q && !engBusy;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			bufFull_q <= 1'b0;
		end else if (launchOk) begin
			bufFull_q <= 1'b1;
		end else if (engStart) begin
			bufFull_q <= 1'b0;
		end
	end

	// done only when nothing buffered or half written
	// launch clears done, held clear while pending
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			doneFlag_q <= 1'b1;
		end else begin
			doneFlag_q <= !launchOk && !bufFull_q && !engBusy &&
				!engStart && seq_q == SEQ_IDLE;
		end
	end

	fpme_erase_engine #(
		.ADDR_W(ADDR_W)
	) u_engine (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.start(engStart),
		.busy(engBusy),
		.eraseStb(eraseStb),
		.eraseAddr(eraseAddr)
	);

	// ----------------------------------------------------------------
	// interrupt requests
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			bufEmptyIrq <= 1'b0;
			doneIrq <= 1'b0;
		end else begin
			bufEmptyIrq <= cfg_q[`FPME_CFG_EMPTY_IE] && bufEmpty;
			doneIrq <= cfg_q[`FPME_CFG_DONE_IE] && doneFlag_q;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence sProtTry;
		launchTry && anyProt;
	endsequence
	sequence sGoodLaunch;
		launchOk ##1 bufFull_q;
	endsequence

	chk_irq_empty: assert property (@(posedge ref_clk) disable iff (!resetn)
		bufEmptyIrq == $past(cfg_q[`FPME_CFG_EMPTY_IE] && bufEmpty))
		else $error("empty request does not follow flag and enable");
	chk_irq_done: assert property (@(posedge ref_clk) disable iff (!resetn)
		!cfg_q[`FPME_CFG_DONE_IE] |=> !doneIrq)
		else $error("done request raised while disabled");
	chk_key_lock: assert property (@(posedge ref_clk) disable iff (!resetn)
		!keyOn |=> $stable(keyGate))
		else $error("key gate changed while keys disabled");
	chk_cfg_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
		acc && avs_read && avs_address == `FPME_OFS_CFG
		|-> avs_readdata[31:8] == 24'h0 && avs_readdata[4:0] == 5'h00)
		else $error("unused configuration bits not zero");
	chk_open_fall: assert property (@(posedge ref_clk) disable iff (!resetn)
		!loadPend_q && !prot_q.open |=> !prot_q.open)
		else $error("open selector rose");
	chk_lo_frozen: assert property (@(posedge ref_clk) disable iff (!resetn)
		!loadPend_q && !prot_q.loDis |=> $stable(prot_q.loSize))
		else $error("low size changed while frozen");
	chk_bad_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		wrLo && avs_address == `FPME_OFS_PROT && !protOk && !loadPend_q
		|=> $stable(prot_q))
		else $error("invalid protection write changed the register");
	chk_viol_block: assert property (@(posedge ref_clk) disable iff (!resetn)
		sProtTry |=> protect_violation_flag_q && !bufFull_q)
		else $error("protected launch not refused");
	chk_launch_run: assert property (@(posedge ref_clk) disable iff (!resetn)
		sGoodLaunch |-> !doneFlag_q ##1 (engBusy && !doneFlag_q))
		else $error("launch did not start erase with done clear");
	chk_done_back: assert property (@(posedge ref_clk) disable iff (!resetn)
		$fell(engBusy) && !bufFull_q && seq_q == SEQ_IDLE && !launchOk
		|=> doneFlag_q)
		else $error("done flag not set after erase");
endmodule
`default_nettype wire

// ### tb/tb_fpme_core.sv
// self-checking bench for the flash controller core
`timescale 1ns/1ps
`default_nettype none
`include "fpme_cfg.svh"
module tb_fpme_core;
	// ------
	// signals
	// ------
	localparam int AW = 3;
	localparam logic [5:0] CFG = `FPME_OFS_CFG;
	localparam logic [5:0] PROT = `FPME_OFS_PROT;
	localparam logic [5:0] CMD = `FPME_OFS_CMD;
	localparam logic [5:0] STAT = `FPME_OFS_STAT;
	localparam logic [5:0] ARR = `FPME_OFS_ARRAY;
	logic refClk = 1'b0;
	logic resetn = 1'b0;
	logic [5:0] avsAddress = 6'h00;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWritedata = 32'h0;
	logic [31:0] avsReaddata;
	logic avsWaitrequest;
	logic [7:0] nvmProt = 8'hff;
	logic [7:0] nvmSec = 8'h00;
	logic bufEmptyIrq;
	logic doneIrq;
	logic keyWordStb;
	logic eraseStb;
	logic [31:0] keyWord;
	logic [AW-1:0] eraseAddr;
	logic [AW-1:0] expAddr = 3'h0;
	logic [31:0] rd;
	int miscompares = 0;
	int numChecks = 0;
	int eraseCnt = 0;
	int keyCnt = 0;

	always #20 refClk = ~refClk;

	fpme_core #(.ADDR_W(AW)) uut (
		.ref_clk(refClk),
		.resetn(resetn),
		.avs_address(avsAddress),
		.avs_read(avsRead),
		.avs_write(avsWrite),
		.avs_writedata(avsWritedata),
		.avs_byteenable(4'hf),
		.avs_readdata(avsReaddata),
		.avs_waitrequest(avsWaitrequest),
		.nvmProt(nvmProt),
		.nvmSec(nvmSec),
		.arrayRdData(32'h5a5a0f0f),
		.bufEmptyIrq(bufEmptyIrq),
		.doneIrq(doneIrq),
		.keyWordStb(keyWordStb),
		.keyWord(keyWord),
		.eraseStb(eraseStb),
		.eraseAddr(eraseAddr)
	);

	// ------
	// tasks
	// ------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		if (miscompares == 0 && numChecks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// one access; the first edge keeps release and next request apart
	task automatic bus(input logic wr, input logic [5:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge refClk);
		avsAddress <= a;
		avsWritedata <= d;
		avsWrite <= wr;
		avsRead <= !wr;
		do begin
			@(posedge refClk);
			n++;
		end while (avsWaitrequest !== 1'b0 && n < 20);
		rd = avsReaddata;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
		if (n >= 20) begin
			miscompares++;
			report_and_stop();
		end
	endtask

	task automatic rdChk(input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
	endtask

	task automatic doReset(input logic [7:0] p, input logic [7:0] s);
		@(posedge refClk);
		resetn <= 1'b0;
		nvmProt <= p;
		nvmSec <= s;
		repeat (5) @(posedge refClk);
		resetn <= 1'b1;
	endtask

	task automatic launchErase;
		bus(1'b1, ARR, 32'h0);
		bus(1'b1, CMD, 32'h41);
		bus(1'b1, STAT, 32'h80);
	endtask

	always @(posedge refClk) begin
		if (eraseStb === 1'b1) begin
			check({29'h0, eraseAddr}, {29'h0, expAddr});
			expAddr = expAddr + 3'h1;
			eraseCnt++;
		end
		if (keyWordStb === 1'b1) begin
			keyCnt++;
		end
	end

	task automatic testCfg;
		bus(1'b1, CFG, 32'hffffffff);
		rdChk(CFG, 32'he0);
		repeat (2) @(posedge refClk);
		check(bufEmptyIrq, 1'b1);
		check(doneIrq, 1'b1);
		bus(1'b1, CFG, 32'h20);
		repeat (2) @(posedge refClk);
		check(bufEmptyIrq, 1'b0);
		check(doneIrq, 1'b0);
		rdChk(6'h3c, 32'h0);
	endtask

	task automatic testKey;
		bus(1'b1, ARR, 32'hcafe0123);
		repeat (2) @(posedge refClk);
		check(keyCnt, 32'h1);
		check(keyWord, 32'hcafe0123);
		rdChk(ARR, 32'hffffffff);
		bus(1'b1, CFG, 32'hc0);
		rdChk(ARR, 32'h5a5a0f0f);
	endtask

	// done must read low once after the launch, then return
	task automatic testErase;
		int n;
		launchErase();
		repeat (2) @(posedge refClk);
		check(bufEmptyIrq, 1'b0);
		rdChk(STAT, 32'h80);
		check(doneIrq, 1'b0);
		n = 0;
		do begin
			bus(1'b0, STAT, 32'h0);
			n++;
		end while (rd[6] !== 1'b1 && n < 50);
		check(rd, 32'hc0);
		check(doneIrq, 1'b1);
		check(eraseCnt, 32'h1 << AW);
	endtask

	task automatic testProt;
		bus(1'b1, PROT, 32'h7f);
		rdChk(PROT, 32'h7f);
		bus(1'b1, PROT, 32'hff);
		rdChk(PROT, 32'h7f);
		bus(1'b1, PROT, 32'h79);
		rdChk(PROT, 32'h79);
		bus(1'b1, PROT, 32'h7a);
		rdChk(PROT, 32'h79);
	endtask

	// open selector now cleared, so the array is protected
	task automatic testViol;
		launchErase();
		repeat (3) @(posedge refClk);
		rdChk(STAT, 32'he0);
		check(eraseCnt, 32'h1 << AW);
		bus(1'b1, CMD, 32'h41);
		rdChk(STAT, 32'hf0);
		bus(1'b1, STAT, 32'h30);
		rdChk(STAT, 32'hc0);
	endtask

	// ------
	// sequence
	// ------
	initial begin
		doReset(8'hff, 8'h00);
		bus(1'b1, CFG, 32'h20);
		rdChk(CFG, 32'h0);
		doReset(8'he7, 8'h80);
		rdChk(PROT, 32'he7);
		testCfg();
		testKey();
		testErase();
		testProt();
		testViol();
		report_and_stop();
	end

	// a hang costs one mismatch and ends the run
	initial begin
		repeat (5000) @(posedge refClk);
		miscompares++;
		report_and_stop();
	end
endmodule
`default_nettype wire
